// [hdl/acc_regs.sv]
// calibration configuration register bank with wishbone slave and sequencer
// Functional notes
// - mode bit 3 enables background offset cal, effective only with bit 1; reset off.
// - mode bit 2 enables foreground offset cal, effective only with bit 0; reset off.
// - mode bit 1 enables background calibration; resets disabled.
// - each start clears stored values, then runs foreground cal if bit 0; resets 1.
// - reference bit 2: 0 mid-code target, 1 match spare converter; resets 0.
// - offset averaging depth is bits 6:4, reset 6, larger means more.
// - linearity averaging depth is bits 2:0, reset 1, larger means more.
// - calibration runs while run-enable high, held in reset while low.
// - read-only foreground done flag rises when foreground cal finishes or skips.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
module acc_regs #(
  parameter int ADDR_W = 10
) (
  // clock, reset, enable
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  // wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [ADDR_W-1:0]            wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [acc_pkg::DAT_W-1:0]    wb_dat_i,
  output logic      [acc_pkg::DAT_W-1:0]    wb_dat_o,
  output logic                              wb_ack_o,
  // calibration engine
  input  wire logic                         fg_cal_done_i,
  output logic                              cal_hold_o,
  output logic                              cal_values_clear_o,
  output logic                              fg_cal_active_o,
  output logic                              foreground_offset_cal_enable_o,
  output logic                              background_cal_enable_o,
  output logic                              background_offset_cal_enable_o,
  output logic                              offset_reference_select_o,
  output logic      [acc_pkg::AVG_W-1:0]    offset_averaging_depth_o,
  output logic      [acc_pkg::AVG_W-1:0]    linearity_averaging_depth_o,
  output logic                              foreground_complete_flag_o,
  // interrupt
  output logic                              irq_o
);

  localparam int IW = ADDR_W - 2;

  function automatic logic acc_hit(input logic [ADDR_W-1:0] adr,
                                   input logic [7:0] idx);
    acc_hit = (adr[ADDR_W-1:2] == IW'(idx));
  endfunction

  // registers
  logic [acc_pkg::REG_W-1:0] run_ff;
  logic [acc_pkg::REG_W-1:0] mode_ff;
  logic [acc_pkg::REG_W-1:0] ref_ff;
  logic [acc_pkg::REG_W-1:0] avg_ff;
  logic [acc_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [acc_pkg::IRQ_W-1:0] irq_mask_ff;
  logic                      ack_ff;
  logic [acc_pkg::DAT_W-1:0] dat_ff;
  logic                      done_sync1_ff;
  logic                      done_sync2_ff;
  logic                      foreground_complete_flag_ff;
  acc_pkg::acc_state_t       state_ff;
  acc_pkg::acc_state_t       nxt_state;
  logic                      fgos_ff;
  logic                      bg_ff;
  logic                      bgos_ff;

  // bus decode
  wire req      = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr       = req & wb_we_i & wb_sel_i[0];
  wire hit_run  = acc_hit(wb_adr_i, acc_pkg::IDX_RUN);
  wire hit_mode = acc_hit(wb_adr_i, acc_pkg::IDX_MODE);
  wire hit_ref  = acc_hit(wb_adr_i, acc_pkg::IDX_REF);
  wire hit_avg  = acc_hit(wb_adr_i, acc_pkg::IDX_AVG);
  wire hit_stat = acc_hit(wb_adr_i, acc_pkg::IDX_STAT);
  wire hit_ist  = acc_hit(wb_adr_i, acc_pkg::IDX_IRQ_STAT);
  wire hit_imk  = acc_hit(wb_adr_i, acc_pkg::IDX_IRQ_MASK);
  wire wr_run   = wr & hit_run;
  wire wr_mode  = wr & hit_mode;
  wire wr_ref   = wr & hit_ref;
  wire wr_avg   = wr & hit_avg;
  wire wr_ist   = wr & hit_ist;
  wire wr_imk   = wr & hit_imk;
  wire [acc_pkg::REG_W-1:0] wbyte = wb_dat_i[acc_pkg::REG_W-1:0];

  // status byte and read mux
  wire [acc_pkg::REG_W-1:0] stat_byte =
    {{(acc_pkg::REG_W-1){1'b0}}, foreground_complete_flag_ff};
  wire [acc_pkg::REG_W-1:0] ist_byte  =
    {{(acc_pkg::REG_W-acc_pkg::IRQ_W){1'b0}}, irq_stat_ff};
  wire [acc_pkg::REG_W-1:0] imk_byte  =
    {{(acc_pkg::REG_W-acc_pkg::IRQ_W){1'b0}}, irq_mask_ff};
  wire [acc_pkg::REG_W-1:0] rd_byte =
    hit_run  ? run_ff    :
    hit_mode ? mode_ff   :
    hit_ref  ? ref_ff    :
    hit_avg  ? avg_ff    :
    hit_stat ? stat_byte :
    hit_ist  ? ist_byte  :
    hit_imk  ? imk_byte  : '0;
  wire [acc_pkg::DAT_W-1:0] nxt_dat =
    {{(acc_pkg::DAT_W-acc_pkg::REG_W){1'b0}}, rd_byte};

  // sequencer inputs
  wire run     = run_ff[acc_pkg::BIT_RUN];
  wire fg_sel  = mode_ff[acc_pkg::BIT_FG];
  wire bg_sel  = mode_ff[acc_pkg::BIT_BG];
  wire cfg_wr  = wr_mode | wr_ref | wr_avg;

  // state decodes
  wire st_hold  = (state_ff == acc_pkg::ST_HOLD);
  wire st_clear = (state_ff == acc_pkg::ST_CLEAR);
  wire st_fg    = (state_ff == acc_pkg::ST_FG_RUN);

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      acc_pkg::ST_HOLD: begin
        if (run) begin
          nxt_state = acc_pkg::ST_CLEAR;
        end
      end
      acc_pkg::ST_CLEAR: begin
        nxt_state = fg_sel ? acc_pkg::ST_FG_RUN : acc_pkg::ST_DONE;
      end
      acc_pkg::ST_FG_RUN: begin
        if (done_sync2_ff) begin
          nxt_state = acc_pkg::ST_DONE;
        end
      end
      acc_pkg::ST_DONE: begin
        nxt_state = acc_pkg::ST_DONE;
      end
    endcase
    if (!run) begin
      nxt_state = acc_pkg::ST_HOLD;
    end
  end

  // interrupt events; flag rises on entry to done
  wire nxt_foreground_complete_flag = (nxt_state == acc_pkg::ST_DONE);
  wire done_event  = nxt_foreground_complete_flag & ~foreground_complete_flag_ff;
  wire cfg_event   = cfg_wr & run;
  wire [acc_pkg::IRQ_W-1:0] irq_set =
    (acc_pkg::IRQ_W'(done_event) << acc_pkg::IRQ_DONE) |
    (acc_pkg::IRQ_W'(cfg_event)  << acc_pkg::IRQ_CFGCHG);
  wire [acc_pkg::IRQ_W-1:0] irq_clr =
    wr_ist ? wbyte[acc_pkg::IRQ_W-1:0] : '0;
  wire [acc_pkg::IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

  // effective enables
  wire nxt_fgos = mode_ff[acc_pkg::BIT_OS] & fg_sel;
  wire nxt_bg   = bg_sel & run;
  wire nxt_bgos = mode_ff[acc_pkg::BIT_BGOS] & nxt_bg;

  // bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req;
    end
  end

  // read data held until the next request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (ce_i && req) begin
      dat_ff <= nxt_dat;
    end
  end

  // run-enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_ff <= acc_pkg::RST_RUN;
    end else if (ce_i && wr_run) begin
      run_ff <= wbyte;
    end
  end

  // mode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= acc_pkg::RST_MODE;
    end else if (ce_i && wr_mode) begin
      mode_ff <= wbyte;
    end
  end

  // reference register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ff <= acc_pkg::RST_REF;
    end else if (ce_i && wr_ref) begin
      ref_ff <= wbyte;
    end
  end

  // averaging register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avg_ff <= acc_pkg::RST_AVG;
    end else if (ce_i && wr_avg) begin
      avg_ff <= wbyte;
    end
  end

  // interrupt status, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else if (ce_i) begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= '0;
    end else if (ce_i && wr_imk) begin
      irq_mask_ff <= wbyte[acc_pkg::IRQ_W-1:0];
    end
  end

  // done input synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_sync1_ff <= 1'b0;
      done_sync2_ff <= 1'b0;
    end else if (ce_i) begin
      done_sync1_ff <= fg_cal_done_i;
      done_sync2_ff <= done_sync1_ff;
    end
  end

  // sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= acc_pkg::ST_HOLD;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // foreground done flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      foreground_complete_flag_ff <= 1'b0;
    end else if (ce_i) begin
      foreground_complete_flag_ff <= nxt_foreground_complete_flag;
    end
  end

  // effective foreground offset enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fgos_ff <= 1'b0;
    end else if (ce_i) begin
      fgos_ff <= nxt_fgos;
    end
  end

  // effective background enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bg_ff <= 1'b0;
    end else if (ce_i) begin
      bg_ff <= nxt_bg;
    end
  end

  // effective background offset enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bgos_ff <= 1'b0;
    end else if (ce_i) begin
      bgos_ff <= nxt_bgos;
    end
  end

  // outputs
  assign wb_ack_o                       = ack_ff;
  assign wb_dat_o                       = dat_ff;
  assign cal_hold_o                     = st_hold;
  assign cal_values_clear_o             = st_clear;
  assign fg_cal_active_o                = st_fg;
  assign foreground_offset_cal_enable_o = fgos_ff;
  assign background_cal_enable_o        = bg_ff;
  assign background_offset_cal_enable_o = bgos_ff;
  assign offset_reference_select_o      = ref_ff[acc_pkg::BIT_OFFSET_REFERENCE_SELECT];
  assign offset_averaging_depth_o       =
    avg_ff[acc_pkg::LSB_OSAVG +: acc_pkg::AVG_W];
  assign linearity_averaging_depth_o    =
    avg_ff[acc_pkg::LSB_LINAVG +: acc_pkg::AVG_W];
  assign foreground_complete_flag_o     = foreground_complete_flag_ff;
  assign irq_o                          = |(irq_stat_ff & irq_mask_ff);

endmodule

// [hdl/acc_pkg.sv]
// constants and types for the calibration configuration register bank
package acc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RUN      = 8'h61;
  localparam logic [7:0] IDX_MODE     = 8'h62;
  localparam logic [7:0] IDX_REF      = 8'h65;
  localparam logic [7:0] IDX_AVG      = 8'h68;
  localparam logic [7:0] IDX_STAT     = 8'h6A;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;

  // reset values
  localparam logic [7:0] RST_RUN  = 8'h01;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_REF  = 8'h01;
  localparam logic [7:0] RST_AVG  = 8'h61;

  // field positions
  localparam int BIT_RUN    = 0;
  localparam int BIT_FG     = 0;
  localparam int BIT_BG     = 1;
  localparam int BIT_OS     = 2;
  localparam int BIT_BGOS   = 3;
  localparam int BIT_OFFSET_REFERENCE_SELECT  = 2;
  localparam int LSB_OSAVG  = 4;
  localparam int LSB_LINAVG = 0;
  localparam int AVG_W      = 3;
  localparam int BIT_DONE   = 0;

  // interrupt status bits
  localparam int IRQ_W      = 2;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_CFGCHG = 1;

  // register byte width and bus data width
  localparam int REG_W = 8;
  localparam int DAT_W = 32;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_CLEAR,
    ST_FG_RUN,
    ST_DONE
  } acc_state_t;

endpackage

// [verif/acc_regs_monitor.sv]
// concurrent checks on the calibration register bank ports
`timescale 1ns/10ps
module acc_regs_mon (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic fg_cal_done_i,
  input wire logic cal_hold_o,
  input wire logic cal_values_clear_o,
  input wire logic fg_cal_active_o,
  input wire logic background_cal_enable_o,
  input wire logic background_offset_cal_enable_o,
  input wire logic foreground_complete_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o ##1 ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not answered");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) && !wb_ack_o |=> !wb_ack_o)
    else $error("ack without request");
  bgos_gate_a: assert property (
    background_offset_cal_enable_o |-> background_cal_enable_o)
    else $error("background offset on without background cal");
  hold_idle_a: assert property (
    cal_hold_o |-> !fg_cal_active_o && !foreground_complete_flag_o && !cal_values_clear_o)
    else $error("activity while held");
  clear_start_a: assert property ($fell(cal_hold_o) |-> cal_values_clear_o)
    else $error("start without clearing values");
  clear_once_a: assert property (cal_values_clear_o ##1 ce_i |=> !cal_values_clear_o)
    else $error("clear pulse too long");
  done_src_a: assert property (
    $rose(foreground_complete_flag_o) |-> $past(fg_cal_active_o) || $past(cal_values_clear_o))
    else $error("done flag from wrong state");
  done_lat_a: assert property (
    fg_cal_active_o && $rose(fg_cal_done_i) |-> ##[1:4] (foreground_complete_flag_o || cal_hold_o))
    else $error("done flag late");
  cover property ($rose(foreground_complete_flag_o));
  cover property (cal_values_clear_o);
  cover property (background_offset_cal_enable_o);
endmodule
bind acc_regs acc_regs_mon i_mon (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .fg_cal_done_i, .cal_hold_o, .cal_values_clear_o, .fg_cal_active_o, .background_cal_enable_o,
  .background_offset_cal_enable_o, .foreground_complete_flag_o);

// [verif/tb.sv]
// self-checking bench for the calibration register bank
`timescale 1ns/10ps
module tb;
  logic        clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0, fg_cal_done_i = 1'h0;
  logic [9:0]  wb_adr_i = 10'h0;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, lf = 32'hcbc1_3411;
  logic        wb_ack_o, cal_hold_o, cal_values_clear_o, fg_cal_active_o, irq_o;
  logic        foreground_offset_cal_enable_o, background_cal_enable_o;
  logic        background_offset_cal_enable_o, offset_reference_select_o;
  logic        foreground_complete_flag_o;
  logic [2:0]  offset_averaging_depth_o, linearity_averaging_depth_o;
  int          err_count = 0, tests_run = 0, cycles = 0;
  int          mdl [int];
  acc_regs i_acc_regs (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fg_cal_done_i, .cal_hold_o,
    .cal_values_clear_o, .fg_cal_active_o, .foreground_offset_cal_enable_o,
    .background_cal_enable_o, .background_offset_cal_enable_o, .offset_reference_select_o,
    .offset_averaging_depth_o, .linearity_averaging_depth_o, .foreground_complete_flag_o,
    .irq_o);
  always #12.5 clk_i = ~clk_i;
  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; also keeps the model's registers
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++n < 20);
    chk(32'(wb_ack_o), 32'h1);
    if (!w) chk(wb_dat_o, mdl.exists(idx) ? 32'(mdl[idx]) : 32'h0);
    if (w && mdl[8'h61][0] && idx inside {8'h62, 8'h65, 8'h68}) mdl[8'h70] |= 2;
    if (w && idx inside {8'h61, 8'h62, 8'h65, 8'h68, 8'h71}) mdl[idx] = d;
    if (w && idx == 8'h70) mdl[idx] &= ~32'(d);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic outs();
    int m = mdl[8'h62], r = mdl[8'h61], p = mdl[8'h65], a = mdl[8'h68];
    chk({foreground_offset_cal_enable_o, background_cal_enable_o, background_offset_cal_enable_o,
      offset_reference_select_o, offset_averaging_depth_o, linearity_averaging_depth_o, irq_o},
      {m[2] & m[0], m[1] & r[0], m[3] & m[1] & r[0], p[2], a[6:4], a[2:0],
      |(mdl[8'h70] & mdl[8'h71])});
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    mdl = '{8'h61: 1, 8'h62: 1, 8'h65: 1, 8'h68: 8'h61, 8'h6A: 0, 8'h70: 0, 8'h71: 0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    outs();
    foreach (mdl[i]) wb(1'h0, 8'(i), 8'h0);
    wb(1'h0, 8'h6F, 8'h0);
    wb(1'h1, 8'h68, 8'h61);
    fg_cal_done_i <= 1'h1;
    for (int n = 0; n < 10 && foreground_complete_flag_o !== 1'h1; n++) @(posedge clk_i);
    fg_cal_done_i <= 1'h0;
    mdl[8'h6A] = 1;
    mdl[8'h70] |= 1;
    wb(1'h1, 8'h6A, 8'h0);
    wb(1'h0, 8'h6A, 8'h0);
    wb(1'h0, 8'h70, 8'h0);
    outs();
    wb(1'h1, 8'h71, 8'h03);
    outs();
    wb(1'h1, 8'h70, 8'h03);
    outs();
    repeat (12) begin
      wb(1'h1, 8'h61, 8'h00);
      mdl[8'h6A] = 0;
      lf = lfsr(lf);
      wb(1'h1, 8'h62, {4'h0, lf[3:0]});
      wb(1'h1, 8'h65, {5'h0, lf[8] & lf[1], 2'h1});
      wb(1'h1, 8'h68, {1'h0, lf[6:4], 1'h0, lf[2:0]});
      outs();
      foreach (mdl[i]) wb(1'h0, 8'(i), 8'h0);
      wb(1'h1, 8'h61, {7'h0, lf[9]});
      if (lf[9] && !lf[0]) mdl[8'h6A] = 1;
      if (lf[9] && !lf[0]) mdl[8'h70] |= 1;
      wb(1'h0, 8'h6A, 8'h0);
      chk({cal_hold_o, fg_cal_active_o}, {~lf[9], lf[9] & lf[0]});
      outs();
    end
    ce_i <= 1'h0;
    fork
      wb(1'h1, 8'h71, 8'h01);
      begin
        repeat (5) @(posedge clk_i);
        ce_i <= 1'h1;
      end
    join
    wb(1'h0, 8'h71, 8'h0);
    outs();
    stop_test();
  end
endmodule
